// File: design/level_detect_consts.vh
/*
 register offsets, field positions, reset values and encodings for the
 level detect and interrupt routing block. assumes plain verilog-2005 includes.
*/
`ifndef LEVEL_DETECT_CONSTS_VH
`define LEVEL_DETECT_CONSTS_VH

// ****************************************
// register offsets
// ****************************************
`define ADDR_MODE_CONTROL 8'h16
`define ADDR_DETECT_CONTROL_ONE 8'h18
`define ADDR_DETECT_CONTROL_TWO 8'h19
`define ADDR_LEVEL_THRESHOLD 8'h1a

// ****************************************
// field positions
// ****************************************
`define MC_DATA_READY_PIN_CTRL 6
`define C1_IRQ_PIN_SWAP 0
`define C1_IRQ_SRC_LO 1
`define C1_IRQ_SRC_HI 2
`define C1_AXIS_X_DISABLE 3
`define C1_AXIS_Y_DISABLE 4
`define C1_AXIS_Z_DISABLE 5
`define C1_COMPARE_TYPE_SELECT 6
`define C2_LEVEL_COMBINE_LOGIC 0
`define C2_PULSE_COMBINE_LOGIC 1
`define C2_DRIVE_STRENGTH_CTRL 2
`define C2_WRITE_MASK 8'h07

// ****************************************
// reset values
// ****************************************
`define RST_MODE_CONTROL 8'h00
`define RST_DETECT_CONTROL_ONE 8'h00
`define RST_DETECT_CONTROL_TWO 8'h00
`define RST_LEVEL_THRESHOLD 8'h00

// ****************************************
// interrupt source encodings
// ****************************************
`define SRC_LEVEL_PULSE 2'h0
`define SRC_PULSE_LEVEL 2'h1
`define SRC_SINGLE_PULSE 2'h2

`endif

// File: design/axis_level_compare.v
/*
 one axis threshold comparator: reports above and below threshold for a signed
 8-bit sample at 16 counts per g. assumes sample and threshold share the scale.
*/
`timescale 1ns/1ns
module axis_level_compare (
	input wire [7:0] sample,
	input wire [7:0] threshold,
	input wire signed_mode,
	output wire above,
	output wire below
);

	// ****************************************
	// magnitude helper
	// ****************************************
	function [8:0] magnitude;
		input [7:0] v;
		begin
			if (v[7]) begin
				magnitude = 9'h100 - {1'b0, v};
			end else begin
				magnitude = {1'b0, v};
			end
		end
	endfunction

	wire signed [8:0] s_sample;
	wire signed [8:0] s_thresh;
	wire [8:0] m_sample;
	wire [8:0] m_thresh;

	// threshold byte is two's complement [RQ14]
	assign s_sample = {sample[7], sample};
	assign s_thresh = {threshold[7], threshold};
	assign m_sample = magnitude(sample);
	assign m_thresh = magnitude(threshold);

	// absolute vs signed comparison [RQ10]
	assign above = signed_mode ? (s_sample > s_thresh) : (m_sample > m_thresh);
	assign below = signed_mode ? (s_sample < s_thresh) : (m_sample < m_thresh);

endmodule // axis_level_compare

// File: design/irq_pin_router.v
/*
 maps two interrupt register bits and sample ready onto the two interrupt pins.
 assumes inputs are registered in the same clock domain.
*/
`timescale 1ns/1ns
module irq_pin_router (
	input wire irq_reg_a,
	input wire irq_reg_b,
	input wire sample_ready,
	input wire irq_pin_swap,
	input wire data_ready_pin_ctrl,
	output wire pin_a,
	output wire pin_b
);

	wire mapped_a;

	// straight or crossed mapping [RQ5] [RQ6]
	assign mapped_a = irq_pin_swap ? irq_reg_b : irq_reg_a;
	assign pin_b = irq_pin_swap ? irq_reg_a : irq_reg_b;
	// first pin may carry data ready instead [RQ4]
	assign pin_a = data_ready_pin_ctrl ? sample_ready : mapped_a;

endmodule // irq_pin_router

// File: design/level_detect_irq_routing.v
/*
 level detection and interrupt routing for a three-axis accelerometer.
 registers are written and read through a simple byte register port that the
 serial interface front end drives in this clock domain; samples, pulse
 detector flags and sample ready also come from logic on the same clock.
*/
// What this block does
// (RQ1) select 00: register a level, register b pulse
// (RQ2) select 01: register a pulse, register b level
// (RQ3) select 10: register a single pulse, b pulse
// (RQ4) mode bit 6 puts sample ready on pin a
// (RQ5) swap clear: register a to pin a
// (RQ6) swap set: pins carry crossed registers
// (RQ7) level check per sample, no timers
// (RQ8) motion or freefall chosen by combine logic
// (RQ9) control two bit 0: OR or AND
// (RQ10) control one bit 6: absolute or signed
// (RQ11) control one bits 3..5 gate x,y,z
// (RQ12) threshold byte register at 0x1a
// (RQ13) threshold scale sixteen counts per g
// (RQ14) threshold is two's complement byte
// (RQ15) axis bit zero enables, one disables
// (RQ16) OR: any above; AND: all below
// (RQ17) host uses read-modify-write on control bits
`timescale 1ns/1ns
`include "level_detect_consts.vh"
module level_detect_irq_routing (
	input wire clk,
	input wire rst_b,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_write,
	input wire reg_read,
	output reg [7:0] reg_rdata,
	input wire [7:0] sample_x,
	input wire [7:0] sample_y,
	input wire [7:0] sample_z,
	input wire sample_valid,
	input wire sample_ready,
	input wire pulse_event,
	input wire single_pulse_event,
	input wire irq_clear,
	output wire irq_line_a,
	output wire irq_line_b,
	output wire level_event,
	output wire drive_strength_ctrl,
	output wire pulse_combine_logic
);

	// ****************************************
	// register file
	// ****************************************
	reg [7:0] mode_control;
	reg [7:0] detect_control_one;
	reg [7:0] detect_control_two;
	reg [7:0] level_threshold;

	// fields are written whole; partial updates are the host's job [RQ17]
	always @(posedge clk) begin
		if (!rst_b) begin
			mode_control <= `RST_MODE_CONTROL;
			detect_control_one <= `RST_DETECT_CONTROL_ONE;
			detect_control_two <= `RST_DETECT_CONTROL_TWO;
			level_threshold <= `RST_LEVEL_THRESHOLD;
		end else if (reg_write) begin
			case (reg_addr)
				`ADDR_MODE_CONTROL: begin
					mode_control <= reg_wdata;
				end
				`ADDR_DETECT_CONTROL_ONE: begin
					detect_control_one <= reg_wdata;
				end
				`ADDR_DETECT_CONTROL_TWO: begin
					// upper bits reserved, held at zero
					detect_control_two <= reg_wdata & `C2_WRITE_MASK;
				end
				`ADDR_LEVEL_THRESHOLD: begin
					level_threshold <= reg_wdata; // [RQ12]
				end
				default: begin
				end
			endcase
		end
	end

	// ****************************************
	// register read
	// ****************************************
	reg [7:0] next_rdata;

	always @* begin
		case (reg_addr)
			`ADDR_MODE_CONTROL: next_rdata = mode_control;
			`ADDR_DETECT_CONTROL_ONE: next_rdata = detect_control_one;
			`ADDR_DETECT_CONTROL_TWO: next_rdata = detect_control_two;
			`ADDR_LEVEL_THRESHOLD: next_rdata = level_threshold;
			default: next_rdata = 8'h00;
		endcase
	end

	// read data lands one clock after the read strobe
	always @(posedge clk) begin
		if (!rst_b) begin
			reg_rdata <= 8'h00;
		end else if (reg_read) begin
			reg_rdata <= next_rdata;
		end
	end

	// ****************************************
	// field decode
	// ****************************************
	wire signed_mode;
	wire and_logic;
	wire [2:0] axis_enable;
	wire [1:0] irq_source_select;

	assign signed_mode = detect_control_one[`C1_COMPARE_TYPE_SELECT]; // [RQ10]
	assign and_logic = detect_control_two[`C2_LEVEL_COMBINE_LOGIC]; // [RQ9]
	// disable bits are active high, so enable is their inverse [RQ11] [RQ15]
	assign axis_enable[0] = ~detect_control_one[`C1_AXIS_X_DISABLE];
	assign axis_enable[1] = ~detect_control_one[`C1_AXIS_Y_DISABLE];
	assign axis_enable[2] = ~detect_control_one[`C1_AXIS_Z_DISABLE];
	assign irq_source_select = detect_control_one[`C1_IRQ_SRC_HI:`C1_IRQ_SRC_LO];
	assign drive_strength_ctrl = detect_control_two[`C2_DRIVE_STRENGTH_CTRL];
	assign pulse_combine_logic = detect_control_two[`C2_PULSE_COMBINE_LOGIC];

	// ****************************************
	// per-axis comparison
	// ****************************************
	wire [2:0] above;
	wire [2:0] below;

	// samples and threshold both at 16 counts per g [RQ13]
	axis_level_compare cmp_x (
		.sample(sample_x),
		.threshold(level_threshold),
		.signed_mode(signed_mode),
		.above(above[0]),
		.below(below[0])
	);

	axis_level_compare cmp_y (
		.sample(sample_y),
		.threshold(level_threshold),
		.signed_mode(signed_mode),
		.above(above[1]),
		.below(below[1])
	);

	axis_level_compare cmp_z (
		.sample(sample_z),
		.threshold(level_threshold),
		.signed_mode(signed_mode),
		.above(above[2]),
		.below(below[2])
	);

	// ****************************************
	// combination logic
	// ****************************************
	wire any_above;
	wire all_below;
	wire level_hit;

	// disabled axes drop out of OR and pass through AND
	assign any_above = |(above & axis_enable);
	assign all_below = &(below | ~axis_enable);
	// with every axis disabled the AND case is forced quiet
	assign level_hit = and_logic ? (all_below & (|axis_enable)) : any_above; // [RQ16] [RQ8]

	// ****************************************
	// interrupt registers
	// ****************************************
	reg level_flag;
	reg irq_reg_a;
	reg irq_reg_b;
	reg next_irq_a;
	reg next_irq_b;
	wire level_set;

	// qualified only by a new sample, no duration or latency [RQ7]
	assign level_set = sample_valid & level_hit;
	assign level_event = level_flag;

	always @* begin
		case (irq_source_select)
			`SRC_PULSE_LEVEL: begin
				next_irq_a = pulse_event; // [RQ2]
				next_irq_b = level_set;
			end
			`SRC_SINGLE_PULSE: begin
				next_irq_a = single_pulse_event; // [RQ3]
				next_irq_b = pulse_event;
			end
			default: begin
				// 11 is undefined; treated like 00
				next_irq_a = level_set; // [RQ1]
				next_irq_b = pulse_event;
			end
		endcase
	end

	// sticky; a new event in the clear cycle wins over the clear
	always @(posedge clk) begin
		if (!rst_b) begin
			level_flag <= 1'b0;
			irq_reg_a <= 1'b0;
			irq_reg_b <= 1'b0;
		end else begin
			level_flag <= level_set | (level_flag & ~irq_clear);
			irq_reg_a <= next_irq_a | (irq_reg_a & ~irq_clear);
			irq_reg_b <= next_irq_b | (irq_reg_b & ~irq_clear);
		end
	end

	// ****************************************
	// pin routing
	// ****************************************
	irq_pin_router router (
		.irq_reg_a(irq_reg_a),
		.irq_reg_b(irq_reg_b),
		.sample_ready(sample_ready),
		.irq_pin_swap(detect_control_one[`C1_IRQ_PIN_SWAP]),
		.data_ready_pin_ctrl(mode_control[`MC_DATA_READY_PIN_CTRL]),
		.pin_a(irq_line_a),
		.pin_b(irq_line_b)
	);

endmodule // level_detect_irq_routing

// File: verification/level_detect_chk.sv
/*
 checker for the level detect and routing block, bound to its top module.
 assumes one clock, synchronous active-low reset, config mirrored from writes.
*/
`timescale 1ns/1ns
module level_detect_chk (
	input wire clk,
	input wire rst_b,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_write,
	input wire reg_read,
	input wire [7:0] reg_rdata,
	input wire sample_valid,
	input wire sample_ready,
	input wire pulse_event,
	input wire single_pulse_event,
	input wire irq_clear,
	input wire irq_line_a,
	input wire irq_line_b,
	input wire level_event
);
	reg [7:0] c1;
	reg [7:0] mc;
	reg [7:0] th;
	reg pw;
	// mirror lands on the same edge as the design's own registers
	always @(posedge clk) begin
		pw <= reg_write;
		if (!rst_b) begin
			c1 <= 8'h00;
			mc <= 8'h00;
			th <= 8'h00;
		end else if (reg_write) begin
			if (reg_addr == 8'h18) c1 <= reg_wdata;
			if (reg_addr == 8'h16) mc <= reg_wdata;
			if (reg_addr == 8'h1a) th <= reg_wdata;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// ****
	// assertions
	// ****
	clear_drop_a: assert property (irq_clear && !sample_valid && !pulse_event && !single_pulse_event |=> !level_event)
		else $error("level flag survived clear");
	level_cause_a: assert property ($rose(level_event) |-> $past(sample_valid))
		else $error("level flag without sample");
	sel_zero_a: assert property ($rose(level_event) && !pw && c1[2:0] == 3'h0 && !mc[6] |-> irq_line_a)
		else $error("level not on pin a");
	sel_swap_a: assert property ($rose(level_event) && !pw && c1[2:0] == 3'h1 |-> irq_line_b)
		else $error("swapped level not on pin b");
	sel_one_a: assert property ($rose(level_event) && !pw && c1[2:0] == 3'h2 |-> irq_line_b)
		else $error("level not in register b");
	pulse_b_a: assert property (pulse_event && !reg_write && c1[2:0] == 3'h0 |=> irq_line_b)
		else $error("pulse not on pin b");
	single_a: assert property (single_pulse_event && !reg_write && c1[2:0] == 3'h4 && !mc[6] |=> irq_line_a)
		else $error("single pulse not on pin a");
	sample_ready_pin_a: assert property (mc[6] |-> irq_line_a == sample_ready)
		else $error("pin a not following sample ready");
	thr_read_a: assert property (reg_read && reg_addr == 8'h1a |=> reg_rdata == $past(th))
		else $error("threshold readback wrong");
endmodule // level_detect_chk
bind level_detect_irq_routing level_detect_chk chk_u (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
	.sample_valid(sample_valid), .sample_ready(sample_ready), .pulse_event(pulse_event),
	.single_pulse_event(single_pulse_event), .irq_clear(irq_clear), .irq_line_a(irq_line_a),
	.irq_line_b(irq_line_b), .level_event(level_event));

// File: verification/host_model.sv
/*
 host side model: byte register port master with one-cycle strobes.
 assumes read data is valid one cycle after the read edge.
*/
`timescale 1ns/1ns
module host_model (
	input wire clk,
	input wire [7:0] reg_rdata,
	output logic [7:0] reg_addr = 8'hff,
	output logic [7:0] reg_wdata = 8'hff,
	output logic reg_write = 1'b0,
	output logic reg_read = 1'b0
);
	// ****
	// bus tasks
	// ****
	task wr(input [7:0] a, input [7:0] d);
		@(posedge clk);
		#2;
		reg_addr = a;
		reg_wdata = d;
		reg_write = 1'b1;
		@(posedge clk);
		#2;
		reg_write = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
	task rd(input [7:0] a, output [7:0] d);
		@(posedge clk);
		#2;
		reg_addr = a;
		reg_read = 1'b1;
		@(posedge clk);
		#2;
		reg_read = 1'b0;
		reg_addr = ~a;
		d = reg_rdata;
	endtask
	// other fields of a shared register keep their values
	task rmw(input [7:0] a, input [7:0] m, input [7:0] o);
		logic [7:0] d;
		rd(a, d);
		wr(a, (d & m) | o);
	endtask
endmodule // host_model

// File: verification/tb_level_detect_irq_routing.sv
/*
 self-checking bench for the level detect and routing block.
 assumes host_model drives the register port and the bound checker.
*/
`timescale 1ns/1ns
module tb_level_detect_irq_routing;
	logic clk = 0, rst_b = 0, sample_valid = 0, sample_ready = 0, pulse_event = 0, single_pulse_event = 0, irq_clear = 0;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rd, v, c1, c2, t, sample_x = 0, sample_y = 0, sample_z = 0;
	logic reg_write, reg_read, irq_line_a, irq_line_b, level_event, drv, pcl;
	logic [23:0] s;
	logic [31:0] seed = 32'he6d4965b;
	logic [7:0] ad [4] = '{8'h16, 8'h18, 8'h19, 8'h1a};
	int fails = 0, n_compared = 0;
	always #10 clk = ~clk;
	host_model host_u (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read));
	level_detect_irq_routing dut_u (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .sample_x(sample_x),
		.sample_y(sample_y), .sample_z(sample_z), .sample_valid(sample_valid), .sample_ready(sample_ready),
		.pulse_event(pulse_event), .single_pulse_event(single_pulse_event), .irq_clear(irq_clear),
		.irq_line_a(irq_line_a), .irq_line_b(irq_line_b), .level_event(level_event),
		.drive_strength_ctrl(drv), .pulse_combine_logic(pcl));
	// ****
	// helpers
	// ****
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// absolute mode compares magnitudes, so 0x80 counts as 128
	function automatic logic lvl(logic [23:0] s, logic [7:0] t, logic [7:0] c1, logic [7:0] c2);
		int a, b;
		logic an, al, any;
		an = 0;
		al = 1;
		any = 0;
		for (int i = 0; i < 3; i++) if (!c1[3+i]) begin
			a = $signed(s[8*i+:8]);
			b = $signed(t);
			if (!c1[6]) begin
				a = a < 0 ? -a : a;
				b = b < 0 ? -b : b;
			end
			any = 1;
			an |= a > b;
			al &= a < b;
		end
		return c2[0] ? al && any : an;
	endfunction
	function automatic logic [1:0] route(int sel, int sw, int k);
		logic [2:0] src;
		logic a, b;
		src = 3'b001 << k;
		// select 11 behaves like 00
		a = sel == 1 ? src[1] : sel == 2 ? src[2] : src[0];
		b = sel == 1 ? src[0] : src[1];
		return sw ? {b, a} : {a, b};
	endfunction
	task chk(logic [7:0] got, logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task strobe(logic [3:0] x);
		@(posedge clk);
		#2 {irq_clear, single_pulse_event, pulse_event, sample_valid} = x;
		@(posedge clk);
		#2 {irq_clear, single_pulse_event, pulse_event, sample_valid} = 4'h0;
	endtask
	task tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// ****
	// scenarios
	// ****
	initial begin
		repeat (6) @(posedge clk);
		#2 rst_b = 1;
		for (int i = 0; i < 4; i++) begin
			host_u.rd(ad[i], rd);
			chk(rd, 8'h00);
			v = rnd();
			host_u.wr(ad[i], v);
			host_u.rd(ad[i], rd);
			chk(rd, ad[i] == 8'h19 ? v & 8'h07 : v);
			if (i == 2) chk({drv, pcl}, v[2:1]);
		end
		host_u.rd(8'h00, rd);
		chk(rd, 8'h00);
		$display("registers done");
		host_u.wr(8'h16, 8'h00);
		for (int i = 0; i < 48; i++) begin
			c1 = rnd() & 8'h78;
			c2 = rnd() & 8'h01;
			t = i == 0 ? 8'h7f : i == 1 ? 8'h80 : rnd();
			// equal to threshold on every axis fires neither OR nor AND
			s = i == 2 ? {3{t}} : rnd();
			host_u.wr(8'h18, c1);
			host_u.wr(8'h19, c2);
			host_u.wr(8'h1a, t);
			strobe(4'h8);
			{sample_z, sample_y, sample_x} = s;
			strobe(4'h1);
			chk(level_event, lvl(s, t, c1, c2));
			chk(irq_line_a, lvl(s, t, c1, c2));
		end
		$display("level detection done");
		host_u.wr(8'h1a, 8'h10);
		host_u.wr(8'h19, 8'h00);
		host_u.wr(8'h18, 8'h30);
		{sample_z, sample_y, sample_x} = 24'h000020;
		for (int sel = 0; sel < 4; sel++) for (int sw = 0; sw < 2; sw++) for (int k = 0; k < 3; k++) begin
			host_u.rmw(8'h18, 8'hf8, 8'(sel * 2 + sw));
			strobe(4'h8);
			strobe(4'(1 << k));
			chk({irq_line_a, irq_line_b}, route(sel, sw, k));
		end
		$display("routing done");
		host_u.wr(8'h16, 8'h40);
		for (int j = 0; j < 2; j++) begin
			sample_ready = j[0];
			@(posedge clk);
			#2 chk(irq_line_a, j[0]);
		end
		$display("sample ready pin done");
		tally_and_finish;
	end
endmodule // tb_level_detect_irq_routing
